// File: logic/ptr_exec.sv
/*
  Executor for the pointer-add and pointer-add-with-return instructions,
  plus decode of literal, jump and call word formats.
  Assumes the core presents each fetched word on INSTR in quarter one
  and supplies the stack top and ALU flag writes in quarter four.
*/
`timescale 1ns/1ps
`default_nettype none
module ptr_exec
  import ptr_exec_pkg::*;
(
  input  wire logic                           CLK,
  input  wire logic                           NRST,
  input  wire logic [15:0]                    INSTR,
  input  wire logic [ptr_exec_pkg::PC_W-1:0]  TOS_VALUE,
  input  wire logic [ptr_exec_pkg::FLAG_W-1:0] ALU_FLAGS,
  input  wire logic                           ALU_FLAGS_WE,
  output var  logic [3:0]                     QUARTER,
  output var  logic [ptr_exec_pkg::PTR_W-1:0] POINTER0,
  output var  logic [ptr_exec_pkg::PTR_W-1:0] POINTER1,
  output var  logic [ptr_exec_pkg::PTR_W-1:0] POINTER2,
  output var  logic [ptr_exec_pkg::PC_W-1:0]  PROGRAM_COUNTER,
  output var  logic [ptr_exec_pkg::FLAG_W-1:0] STATUS_FLAGS,
  output var  logic                           STACK_POP,
  output var  logic                           JUMP_TAKEN,
  output var  logic                           CALL_TAKEN,
  output var  logic                           FAST_SELECT,
  output var  logic                           NOP_CYCLE,
  output var  logic [7:0]                     LITERAL_OPCODE,
  output var  logic [7:0]                     LITERAL_VALUE
);
  import ptr_exec_pkg::*;

  typedef struct packed {
    state_t                  st;
    logic [3:0]              q;
    logic [15:0]             ir;
    logic [1:0]              sel;
    logic [LIT_W-1:0]        lit;
    logic [PTR_W-1:0]        sum;
    logic [2:0][PTR_W-1:0]   ptr;
    logic [PC_W-1:0]         pc;
    logic [7:0]              tgt_lo;
    logic                    kind_call;
    logic [FLAG_W-1:0]       flags;
    logic                    pop;
    logic                    jump;
    logic                    call;
    logic                    fast;
    logic [7:0]              lop;
    logic [7:0]              lval;
  } core_t;

  core_t r;
  core_t n;

  dec_if dec (.clk(CLK), .rst_n(NRST));

  word_decoder u_dec (.d(dec));

  // Select three falls back to pointer two
  function automatic logic [PTR_W-1:0] ptr_pick(
    input logic [2:0][PTR_W-1:0] p,
    input logic [1:0]            s
  );
    logic [PTR_W-1:0] v;
    v = p[2];
    if (s == 2'h0) begin
      v = p[0];
    end else if (s == 2'h1) begin
      v = p[1];
    end
    return v;
  endfunction

  logic             run_now;
  logic             add_now;
  logic             ret_now;
  logic [PTR_W-1:0] lit_ext;
  logic [PC_W-1:0]  jump_tgt;

  assign dec.word = r.ir;
  assign run_now  = (r.st == ST_RUN);
  assign add_now  = run_now && dec.is_add;
  assign ret_now  = run_now && dec.is_ret;
  assign lit_ext  = {{(PTR_W-LIT_W){1'b0}}, r.lit};
  assign jump_tgt = {dec.target_hi, r.tgt_lo};

  always_comb begin
    n      = r;
    n.q    = {r.q[2:0], r.q[3]};
    n.pop  = 1'b0;
    n.jump = 1'b0;
    n.call = 1'b0;
    // Q1: take the fetched word; the word after a return add is flushed
    if (r.q[0] && r.st != ST_NOP) begin
      n.ir = INSTR;
    end
    // Q2: read literal and the literal-operation fields
    if (r.q[1] && run_now) begin
      n.lit  = dec.lit;
      n.sel  = dec.sel;
      n.lop  = dec.opcode;
      n.lval = dec.imm;
    end
    // Q3: full-width sum, carry reaches the high part
    if (r.q[2] && run_now) begin
      n.sum = ptr_pick(r.ptr, r.sel) + lit_ext;
    end
    // Q4: write back and sequence the next instruction cycle
    if (r.q[3]) begin
      case (r.st)
        ST_RUN: begin
          for (int i = 0; i < 3; i++) begin
            if (add_now && r.sel == 2'(i)) begin
              n.ptr[i] = r.sum;
            end
          end
          if (ret_now) begin
            n.ptr[2] = r.sum;
            n.pc     = TOS_VALUE;
            n.pop    = 1'b1;
            n.st     = ST_NOP;
          end else begin
            n.pc = r.pc + 20'h00001;
            if (dec.is_jump || dec.is_call) begin
              n.tgt_lo    = dec.imm;
              n.kind_call = dec.is_call;
              n.fast      = dec.is_call && dec.fast;
              n.st        = ST_SECOND;
            end
          end
          // Pointer adds never disturb the flags
          if (ALU_FLAGS_WE && !add_now && !ret_now) begin
            n.flags = ALU_FLAGS;
          end
        end
        ST_SECOND: begin
          if (dec.prefix_ok) begin
            n.pc   = jump_tgt;
            n.jump = !r.kind_call;
            n.call = r.kind_call;
          end else begin
            n.pc = r.pc + 20'h00001;
          end
          n.st = ST_RUN;
        end
        ST_NOP: begin
          n.st = ST_RUN;
        end
        default: begin
          n.st = ST_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      r.st        <= ST_RUN;
      r.q         <= Q_FIRST;
      r.ir        <= 16'h0000;
      r.sel       <= 2'h0;
      r.lit       <= 6'h00;
      r.sum       <= PTR_RESET;
      r.ptr       <= {3{PTR_RESET}};
      r.pc        <= PC_RESET;
      r.tgt_lo    <= 8'h00;
      r.kind_call <= 1'b0;
      r.flags     <= FLAGS_RESET;
      r.pop       <= 1'b0;
      r.jump      <= 1'b0;
      r.call      <= 1'b0;
      r.fast      <= 1'b0;
      r.lop       <= 8'h00;
      r.lval      <= 8'h00;
    end else begin
      r <= n;
    end
  end

  assign QUARTER         = r.q;
  assign POINTER0        = r.ptr[0];
  assign POINTER1        = r.ptr[1];
  assign POINTER2        = r.ptr[2];
  assign PROGRAM_COUNTER = r.pc;
  assign STATUS_FLAGS    = r.flags;
  assign STACK_POP       = r.pop;
  assign JUMP_TAKEN      = r.jump;
  assign CALL_TAKEN      = r.call;
  assign FAST_SELECT     = r.fast;
  assign NOP_CYCLE       = (r.st == ST_NOP);
  assign LITERAL_OPCODE  = r.lop;
  assign LITERAL_VALUE   = r.lval;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  sequence s_ret_decoded;
    r.q[1] && ret_now;
  endsequence

  sequence s_ret_quarters;
    r.q[2] ##1 (r.q[3] && ret_now) ##1 (r.q[0] && r.st == ST_NOP);
  endsequence

  // Pop pulse and the pointer write land in the first idle quarter
  sequence s_nop_cycle;
    (r.st == ST_NOP && STACK_POP) ##1
      (r.st == ST_NOP && $stable(r.ptr) && $stable(r.pc)
        && !STACK_POP)[*3];
  endsequence

  quarter_ring_a: assert property (
    $onehot(r.q) and (r.q[3] |=> r.q[0]))
    else $error("quarter phases out of order");
  pointer_sum_a: assert property (
    (r.q[3] && add_now && r.sel == 2'h0)
      |=> POINTER0 == $past(POINTER0) + 12'($past(r.lit)))
    else $error("pointer zero sum wrong");
  flags_kept_a: assert property (
    (r.q[3] && (add_now || ret_now)) |=> $stable(STATUS_FLAGS))
    else $error("flags changed by pointer add");
  add_one_cycle_a: assert property (
    (r.q[3] && add_now)
      |=> (r.st == ST_RUN && PROGRAM_COUNTER == $past(r.pc) + 20'h1))
    else $error("pointer add not single cycle");
  ret_phases_a: assert property (
    s_ret_decoded |=> s_ret_quarters)
    else $error("return add quarter sequence wrong");
  ret_load_a: assert property (
    (r.q[3] && ret_now) |=> (PROGRAM_COUNTER == $past(TOS_VALUE)
      && POINTER2 == $past(r.sum) && STACK_POP))
    else $error("return add did not load counter");
  nop_second_a: assert property (
    (r.q[3] && ret_now) |=> s_nop_cycle ##1 (r.st == ST_RUN))
    else $error("second cycle not idle");
  jump_target_a: assert property (
    (r.st == ST_SECOND && r.q[3] && dec.prefix_ok)
      |=> (PROGRAM_COUNTER == $past(jump_tgt)
           && (JUMP_TAKEN || CALL_TAKEN)))
    else $error("jump target not loaded");
  literal_fields_a: assert property (
    (r.q[1] && run_now) |=> (LITERAL_OPCODE == $past(r.ir[15:8])
      && LITERAL_VALUE == $past(r.ir[7:0])))
    else $error("literal fields not captured");
endmodule
`default_nettype wire

// File: logic/ptr_exec_pkg.sv
/*
  Constants and types shared by the pointer-add instruction executor,
  its word decoder and the interface that joins them.
  Assumes one core clock and one quarter phase per clock cycle.
*/
`default_nettype none
package ptr_exec_pkg;
  localparam int                PTR_W          = 12;
  localparam int                PC_W           = 20;
  localparam int                LIT_W          = 6;
  localparam int                FLAG_W         = 5;
  localparam logic [7:0]        ADD_PTR_OPCODE = 8'he8;
  localparam logic [1:0]        RET_SELECT     = 2'h3;
  localparam logic [7:0]        JUMP_OPCODE    = 8'hef;
  localparam logic [6:0]        CALL_OPCODE    = 7'h76;
  localparam logic [3:0]        SECOND_PREFIX  = 4'hf;
  localparam int                FAST_BIT       = 8;
  localparam logic [PTR_W-1:0]  PTR_RESET      = 12'h000;
  localparam logic [PC_W-1:0]   PC_RESET       = 20'h00000;
  localparam logic [FLAG_W-1:0] FLAGS_RESET    = 5'h00;
  localparam logic [3:0]        Q_FIRST        = 4'h1;
  localparam int                QUARTERS       = 4;

  typedef enum logic [2:0] {
    ST_RUN    = 3'h1,
    ST_SECOND = 3'h2,
    ST_NOP    = 3'h4
  } state_t;
endpackage
`default_nettype wire

// File: logic/dec_if.sv
/*
  Interface between the executor and its word decoder.
  Assumes the executor drives the word and owns clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
interface dec_if
  import ptr_exec_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n
);
  logic [15:0]      word;
  logic             is_add;
  logic             is_ret;
  logic             is_jump;
  logic             is_call;
  logic             fast;
  logic             prefix_ok;
  logic [1:0]       sel;
  logic [LIT_W-1:0] lit;
  logic [7:0]       opcode;
  logic [7:0]       imm;
  logic [11:0]      target_hi;

  modport decoder (
    input  clk, rst_n, word,
    output is_add, is_ret, is_jump, is_call, fast, prefix_ok,
    output sel, lit, opcode, imm, target_hi
  );
  modport core (
    output word,
    input  is_add, is_ret, is_jump, is_call, fast, prefix_ok,
    input  sel, lit, opcode, imm, target_hi
  );
endinterface
`default_nettype wire

// File: logic/word_decoder.sv
/*
  Field decoder for one 16-bit instruction word.
  Assumes the word is held stable from the second quarter onward.
*/
`timescale 1ns/1ps
`default_nettype none
module word_decoder
  import ptr_exec_pkg::*;
(
  dec_if.decoder d
);
  always_comb begin
    d.opcode    = d.word[15:8];
    d.imm       = d.word[7:0];
    d.sel       = d.word[7:6];
    d.lit       = d.word[LIT_W-1:0];
    d.is_add    = (d.word[15:8] == ADD_PTR_OPCODE) &&
                  (d.word[7:6] != RET_SELECT);
    d.is_ret    = (d.word[15:8] == ADD_PTR_OPCODE) &&
                  (d.word[7:6] == RET_SELECT);
    d.is_jump   = (d.word[15:8] == JUMP_OPCODE);
    d.is_call   = (d.word[15:9] == CALL_OPCODE);
    d.fast      = d.word[FAST_BIT];
    d.prefix_ok = (d.word[15:12] == SECOND_PREFIX);
    d.target_hi = d.word[11:0];
  end

  default clocking cb @(posedge d.clk); endclocking
  default disable iff (!d.rst_n);

  add_decode_a: assert property (
    (d.word[15:8] == 8'he8 && d.word[7:6] != 2'h3)
      |-> (d.is_add && !d.is_ret && d.lit == d.word[5:0]))
    else $error("pointer add not decoded");
  ret_decode_a: assert property (
    (d.word[15:6] == 10'h3a3) |-> (d.is_ret && !d.is_add))
    else $error("select three not decoded as return add");
  fast_bit_a: assert property (
    d.is_call |-> (d.fast == d.word[8] && !d.is_jump))
    else $error("fast select not taken from call word");
endmodule
`default_nettype wire

// File: tb/pointer_add_instruction_decode_test.sv
/*
  Self-checking bench for the pointer-add instruction executor.
  Assumes ptr_exec_pkg and the ptr_exec design are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module pointer_add_instruction_decode_test
  import ptr_exec_pkg::*;
;
  typedef struct packed {
    logic [11:0] p0, p1, p2;
    logic [19:0] pc;
    logic [4:0]  fl;
    logic        pop, jmp, call, fast, no_operation, chk;
    logic [7:0]  lop, lval;
  } exp_t;

  logic              CLK, NRST, ALU_FLAGS_WE;
  logic [15:0]       INSTR;
  logic [PC_W-1:0]   TOS_VALUE, PROGRAM_COUNTER;
  logic [FLAG_W-1:0] ALU_FLAGS, STATUS_FLAGS;
  logic [3:0]        QUARTER, qx;
  logic [PTR_W-1:0]  POINTER0, POINTER1, POINTER2;
  logic              STACK_POP, JUMP_TAKEN, CALL_TAKEN, FAST_SELECT;
  logic              NOP_CYCLE, second, is_call, nop_pend;
  logic [7:0]        LITERAL_OPCODE, LITERAL_VALUE, tgt;
  int                n_mismatch, compares, seed, i, r;
  exp_t              q[$];
  exp_t              m, e;

  ptr_exec uut (
    .CLK(CLK), .NRST(NRST), .INSTR(INSTR), .TOS_VALUE(TOS_VALUE),
    .ALU_FLAGS(ALU_FLAGS), .ALU_FLAGS_WE(ALU_FLAGS_WE), .QUARTER(QUARTER),
    .POINTER0(POINTER0), .POINTER1(POINTER1), .POINTER2(POINTER2),
    .PROGRAM_COUNTER(PROGRAM_COUNTER), .STATUS_FLAGS(STATUS_FLAGS),
    .STACK_POP(STACK_POP), .JUMP_TAKEN(JUMP_TAKEN),
    .CALL_TAKEN(CALL_TAKEN), .FAST_SELECT(FAST_SELECT),
    .NOP_CYCLE(NOP_CYCLE), .LITERAL_OPCODE(LITERAL_OPCODE),
    .LITERAL_VALUE(LITERAL_VALUE)
  );

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic results();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [19:0] seen, input logic [19:0] want,
                       input string what);
    compares++;
    if (seen !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h",
               $time, what, seen, want);
    end
  endtask

  // One instruction cycle: drive the word, note the state after it
  task automatic step(input logic [15:0] w, input logic [4:0] f,
                      input logic we);
    exp_t        n;
    logic [19:0] top_of_stack_value;
    logic [11:0] k;
    n = m;
    top_of_stack_value = 20'($random(seed));
    k = {6'h00, w[5:0]};
    n.pop = 1'b0;
    n.jmp = 1'b0;
    n.call = 1'b0;
    n.no_operation = 1'b0;
    INSTR <= w;
    ALU_FLAGS <= f;
    ALU_FLAGS_WE <= we;
    TOS_VALUE <= top_of_stack_value;
    if (nop_pend) begin
      nop_pend = 1'b0;
      n.chk = 1'b0;
    end else if (second) begin
      second = 1'b0;
      n.chk = 1'b0;
      if (w[15:12] == SECOND_PREFIX) begin
        n.pc = {w[11:0], tgt};
        n.call = is_call;
        n.jmp = !is_call;
      end else
        n.pc = m.pc + 20'h1;
    end else begin
      n.chk = 1'b1;
      n.lop = w[15:8];
      n.lval = w[7:0];
      n.pc = m.pc + 20'h1;
      if (w[15:8] == ADD_PTR_OPCODE) begin
        case (w[7:6])
          2'h0: n.p0 = m.p0 + k;
          2'h1: n.p1 = m.p1 + k;
          2'h2: n.p2 = m.p2 + k;
          default: begin
            n.p2 = m.p2 + k;
            n.pc = top_of_stack_value;
            n.pop = 1'b1;
            n.no_operation = 1'b1;
            nop_pend = 1'b1;
          end
        endcase
      end else begin
        if (we)
          n.fl = f;
        if (w[15:8] == JUMP_OPCODE || w[15:9] == CALL_OPCODE) begin
          second = 1'b1;
          tgt = w[7:0];
          is_call = (w[15:9] == CALL_OPCODE);
          n.fast = is_call & w[FAST_BIT];
        end
      end
    end
    m = n;
    q.push_back(n);
    repeat (4) @(posedge CLK);
  endtask

  // Watch outputs; one noted state is due at each first quarter
  initial begin
    qx = 4'h1;
    forever begin
      @(negedge CLK);
      if (NRST === 1'b1) begin
        check(QUARTER, qx, "quarter");
        if (QUARTER === 4'h1 && q.size() > 0) begin
          e = q.pop_front();
          check(POINTER0, e.p0, "pointer0");
          check(POINTER1, e.p1, "pointer1");
          check(POINTER2, e.p2, "pointer2");
          check(PROGRAM_COUNTER, e.pc, "counter");
          check(STATUS_FLAGS, e.fl, "flags");
          check(STACK_POP, e.pop, "pop");
          check(NOP_CYCLE, e.no_operation, "idle");
          check(JUMP_TAKEN, e.jmp, "jump");
          check(CALL_TAKEN, e.call, "call");
          check(FAST_SELECT, e.fast, "fast");
          if (e.chk) begin
            check(LITERAL_OPCODE, e.lop, "opcode");
            check(LITERAL_VALUE, e.lval, "value");
          end
        end
        qx = {qx[2:0], qx[3]};
      end else
        qx = 4'h1;
    end
  end

  initial begin
    #200000;
    n_mismatch++;
    results();
  end

  initial begin
    seed = 32'h7ea4ef50;
    NRST = 1'b0;
    INSTR = 16'h0000;
    TOS_VALUE = '0;
    ALU_FLAGS = '0;
    ALU_FLAGS_WE = 1'b0;
    second = 1'b0;
    nop_pend = 1'b0;
    m = '0;
    m.chk = 1'b1;
    q.push_back(m);
    repeat (12) @(posedge CLK);
    NRST <= 1'b1;
    for (i = 0; i < 17; i++)
      step(16'he87f, 5'h1f, 1'b1);
    step(16'h0e5a, 5'h15, 1'b1);
    step(16'he823, 5'h0a, 1'b1);
    step(16'he8a3, 5'h0a, 1'b1);
    step(16'he8e3, 5'h1f, 1'b1);
    step(16'he81f, 5'h1f, 1'b1);
    step(16'he8c0, 5'h00, 1'b0);
    step(16'he801, 5'h00, 1'b0);
    step(16'hef12, 5'h03, 1'b1);
    step(16'hf345, 5'h1c, 1'b1);
    step(16'hec56, 5'h00, 1'b0);
    step(16'hfabc, 5'h00, 1'b0);
    step(16'hed9a, 5'h00, 1'b0);
    step(16'hf001, 5'h00, 1'b0);
    step(16'hef77, 5'h00, 1'b0);
    step(16'h0000, 5'h00, 1'b0);
    for (i = 0; i < 150; i++) begin
      r = $random(seed);
      case (r[1:0])
        2'h0: step({8'he8, r[23:16]}, r[8:4], r[9]);
        2'h2: begin
          step({7'h76 | {6'h00, r[2]}, r[3], r[23:16]}, r[8:4], r[9]);
          step({4'hf, r[31:20]}, r[8:4], r[9]);
        end
        default: step({1'b0, r[30:16]}, r[8:4], r[9]);
      endcase
    end
    repeat (8) @(posedge CLK);
    check(20'(q.size()), 20'h0, "pending");
    results();
  end
endmodule
`default_nettype wire
